/* File: src/flash_ctrl_consts.svh */
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define IDX_MODE_CONTROL 6'h00
`define IDX_ERROR_STATUS 6'h01
`define IDX_POWER_CONTROL 6'h02
`define IDX_BLOCK_SELECT 6'h03
`define IDX_REGISTER_GATE 6'h04

// ****************************************************************
// field positions
// ****************************************************************
`define MC_WRITE_ENABLE 6
`define MC_ERASE_SETUP 5
`define MC_PROGRAM_SETUP 4
`define MC_ERASE_VERIFY 3
`define MC_PROGRAM_VERIFY 2
`define MC_ERASE 1
`define MC_PROGRAM 0
`define ST_ARRAY_ERROR 7
`define PC_POWERDOWN_DISABLE 7
`define RG_CONTROL_ENABLE 7
`define BLOCK_COUNT 5

// ****************************************************************
// reset values
// ****************************************************************
`define RST_MODE_CONTROL 7'h00
`define RST_BLOCK_SELECT 5'h00

// ****************************************************************
// block map, top address of each small block and of the array
// ****************************************************************
`define BLK0_TOP 15'h03ff
`define BLK1_TOP 15'h07ff
`define BLK2_TOP 15'h0bff
`define BLK3_TOP 15'h0fff
`define BLK4_TOP 15'h7fff

`endif

/* File: src/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic program_mode;
        logic erase_mode;
        logic program_verify;
        logic erase_verify;
        logic program_setup;
        logic erase_setup;
    } array_modes_t;

    typedef enum logic [1:0] {
        BOOTSEL_UNKNOWN = 2'b00,
        BOOTSEL_USER = 2'b01,
        BOOTSEL_BOOT = 2'b10,
        BOOTSEL_OTHER = 2'b11
    } startup_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01,
        BUS_RELEASE = 2'b10
    } bus_state_t;

endpackage

/* File: src/flash_program_erase_control.sv */
// Overview of operation
// - erase-setup bit set enters erase setup; cleared (reset value) cancels it.
// - program-setup bit 4 set enters program setup; clearing cancels it.
// - erase-verify bit 3 enters and leaves erase-verify mode; resets to 0.
// - program-verify bit 2 enters and leaves program-verify mode; resets to 0.
// - erase bit 1 enters erase mode only with write-enable and erase-setup.
// - program bit 0 enters program mode only with write-enable and program-setup.
// - an error during program or erase sets status bit 7 and protects.
// - status register is read-only; software does not write it.
// - unused bits 6..0 of status, power, gate registers read 0.
// - block select register is held cleared while write-enable is 0.
// - writing more than one block-select bit clears the whole register.
// - only the selected block may be erased; others stay protected.
// - select bits 0..3 map to 1-kbyte blocks; bit 4 to 0x1000-0x7fff.
// - entering subactive powers the array down unless power-down disable is 1.
// - control-enable bit 7 gates access to the other four registers.
// - after reset, test 0 and boot-select 1 is user; both 0 plus enable is boot.
// - boot mode starts the built-in loader that erases and reprograms.
// - with write-enable 0, program and erase are off and sets are ignored.
// - all five registers are 8 bits, byte access, two-state access.

`include "flash_ctrl_consts.svh"

module flash_program_erase_control #(
    parameter int ADDR_W = 8,
    parameter int ARRAY_AW = 15
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // array side, same clock
    input wire logic [ARRAY_AW-1:0] array_addr,
    input wire logic array_fault,
    input wire logic subactive_req,
    output flash_ctrl_pkg::array_modes_t array_modes,
    output logic [`BLOCK_COUNT-1:0] block_erase_enable,
    output logic erase_addr_allowed,
    output logic array_powerdown,
    output logic array_error,
    // mode pins, asynchronous
    input wire logic test_pin,
    input wire logic boot_select_pin,
    input wire logic boot_enable_pin,
    output logic user_mode,
    output logic boot_mode
);
    import flash_ctrl_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (ADDR_W < 8) begin : g_bad_addr
        $error("address too narrow for the register map");
    end
    if (ARRAY_AW < 15) begin : g_bad_array
        $error("array address too narrow for the block map");
    end

    // ****************************************************************
    // decoding functions
    // ****************************************************************
    function automatic logic [`BLOCK_COUNT-1:0] block_of(input logic [14:0] a);
        logic [`BLOCK_COUNT-1:0] hit;
        hit = 5'h00;
        if (a <= `BLK0_TOP) begin
            hit = 5'h01;
        end else if (a <= `BLK1_TOP) begin
            hit = 5'h02;
        end else if (a <= `BLK2_TOP) begin
            hit = 5'h04;
        end else if (a <= `BLK3_TOP) begin
            hit = 5'h08;
        end else if (a <= `BLK4_TOP) begin
            hit = 5'h10;
        end
        return hit;
    endfunction

    function automatic logic more_than_one(input logic [`BLOCK_COUNT-1:0] v);
        return (v & (v - 5'h01)) != 5'h00;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    bus_state_t bus_q, bus_d;
    logic [6:0] mode_q, mode_d;
    logic [`BLOCK_COUNT-1:0] blk_q, blk_d;
    logic error_q, error_d;
    logic pdwn_dis_q, pdwn_dis_d;
    logic gate_q, gate_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    array_modes_t modes_q, modes_d;
    logic [`BLOCK_COUNT-1:0] blk_en_q;
    logic addr_ok_q, addr_ok_d;
    logic pwdn_q;
    logic [2:0] pin_meta_q, pin_sync_q;
    logic started_q;
    logic user_q, boot_q;
    startup_mode_t start_d;

    // ****************************************************************
    // bus slave: one wait cycle, answer in the second state
    // ****************************************************************
    wire req = read | write;
    wire [5:0] idx = address[7:2];
    wire lane0 = byteenable[0];
    wire answer = (bus_q == BUS_ANSWER);
    wire wr_take = answer & write & lane0;
    wire [7:0] wbyte = writedata[7:0];

    wire sel_mode = (idx == `IDX_MODE_CONTROL);
    wire sel_stat = (idx == `IDX_ERROR_STATUS);
    wire sel_pwr = (idx == `IDX_POWER_CONTROL);
    wire sel_blk = (idx == `IDX_BLOCK_SELECT);
    wire sel_gate = (idx == `IDX_REGISTER_GATE);

    // gated registers are invisible until the control-enable bit is set
    wire open_q = gate_q;
    wire wr_mode = wr_take & sel_mode & open_q;
    wire wr_pwr = wr_take & sel_pwr & open_q;
    wire wr_blk = wr_take & sel_blk & open_q;
    wire wr_gate = wr_take & sel_gate;
    // status writes are dropped on purpose
    wire wr_stat_dropped = wr_take & sel_stat;

    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            BUS_IDLE: begin
                if (req) begin
                    bus_d = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_d = BUS_RELEASE;
            end
            BUS_RELEASE: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    // waitrequest falls for the answer state only
    assign wait_d = !(bus_d == BUS_ANSWER);

    // ****************************************************************
    // read mux
    // ****************************************************************
    wire [7:0] rd_mode = {1'b0, mode_q};
    wire [7:0] rd_stat = {error_q, 7'h00};
    wire [7:0] rd_pwr = {pdwn_dis_q, 7'h00};
    wire [7:0] rd_blk = {3'h0, blk_q};
    wire [7:0] rd_gate = {gate_q, 7'h00};
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (sel_gate) begin
            rd_byte = rd_gate;
        end else if (!open_q) begin
            rd_byte = 8'h00;
        end else if (sel_mode) begin
            rd_byte = rd_mode;
        end else if (sel_stat) begin
            rd_byte = rd_stat;
        end else if (sel_pwr) begin
            rd_byte = rd_pwr;
        end else if (sel_blk) begin
            rd_byte = rd_blk;
        end
    end

    assign rdata_d = (bus_d == BUS_ANSWER && read) ? {24'h000000, rd_byte} : rdata_q;

    // ****************************************************************
    // mode control register
    // ****************************************************************
    wire [6:0] wm = wbyte[6:0];
    wire wen_now = mode_q[`MC_WRITE_ENABLE];
    wire erase_ready = mode_q[`MC_ERASE_SETUP];
    wire program_ready = mode_q[`MC_PROGRAM_SETUP];
    // a program request while erasing (or the reverse) counts as a fault
    wire clash = wr_mode & wen_now & ((wm[`MC_PROGRAM] & mode_q[`MC_ERASE]) |
        (wm[`MC_ERASE] & mode_q[`MC_PROGRAM]));
    wire active = mode_q[`MC_ERASE] | mode_q[`MC_PROGRAM];
    wire fault_seen = (array_fault & active) | clash;

    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            if (!wm[`MC_WRITE_ENABLE]) begin
                mode_d = `RST_MODE_CONTROL;
            end else if (!wen_now) begin
                // other bits cannot be set in the same write as enable
                mode_d = 7'h40;
            end else begin
                mode_d[`MC_ERASE_SETUP] = wm[`MC_ERASE_SETUP];
                mode_d[`MC_PROGRAM_SETUP] = wm[`MC_PROGRAM_SETUP];
                mode_d[`MC_ERASE_VERIFY] = wm[`MC_ERASE_VERIFY];
                mode_d[`MC_PROGRAM_VERIFY] = wm[`MC_PROGRAM_VERIFY];
                mode_d[`MC_ERASE] = wm[`MC_ERASE] & erase_ready & !error_q;
                mode_d[`MC_PROGRAM] = wm[`MC_PROGRAM] & program_ready & !error_q;
            end
        end
        if (error_d) begin
            // protection drops any running program or erase
            mode_d[`MC_ERASE] = 1'b0;
            mode_d[`MC_PROGRAM] = 1'b0;
        end
    end

    // sticky until reset; the array has no software clear for it
    assign error_d = error_q | fault_seen;

    // ****************************************************************
    // block select register
    // ****************************************************************
    wire wen_next = mode_d[`MC_WRITE_ENABLE];

    always_comb begin
        blk_d = blk_q;
        if (wr_blk && wen_now) begin
            if (more_than_one(wbyte[4:0])) begin
                blk_d = `RST_BLOCK_SELECT;
            end else begin
                blk_d = wbyte[4:0];
            end
        end
        if (!wen_next) begin
            blk_d = `RST_BLOCK_SELECT;
        end
    end

    // ****************************************************************
    // power and gate registers
    // ****************************************************************
    assign pdwn_dis_d = wr_pwr ? wbyte[`PC_POWERDOWN_DISABLE] : pdwn_dis_q;
    assign gate_d = wr_gate ? wbyte[`RG_CONTROL_ENABLE] : gate_q;

    // ****************************************************************
    // array-facing outputs
    // ****************************************************************
    wire wen_d = mode_d[`MC_WRITE_ENABLE];
    wire erase_on = wen_d & mode_d[`MC_ERASE_SETUP] & mode_d[`MC_ERASE];
    wire prog_on = wen_d & mode_d[`MC_PROGRAM_SETUP] & mode_d[`MC_PROGRAM];

    always_comb begin
        modes_d.program_mode = prog_on;
        modes_d.erase_mode = erase_on;
        modes_d.program_verify = wen_d & mode_d[`MC_PROGRAM_VERIFY];
        modes_d.erase_verify = wen_d & mode_d[`MC_ERASE_VERIFY];
        modes_d.program_setup = wen_d & mode_d[`MC_PROGRAM_SETUP];
        modes_d.erase_setup = wen_d & mode_d[`MC_ERASE_SETUP];
    end

    wire [`BLOCK_COUNT-1:0] blk_en_d = erase_on ? blk_d : 5'h00;
    // unselected blocks never see an erase enable
    assign addr_ok_d = |(block_of(array_addr[14:0]) & blk_en_d);
    wire pwdn_d = subactive_req & !pdwn_dis_d;

    // ****************************************************************
    // startup mode selection from pins
    // ****************************************************************
    wire pin_test = pin_sync_q[2];
    wire pin_bsel = pin_sync_q[1];
    wire pin_ben = pin_sync_q[0];

    always_comb begin
        start_d = BOOTSEL_OTHER;
        if (!pin_test && pin_bsel) begin
            start_d = BOOTSEL_USER;
        end else if (!pin_test && !pin_bsel && pin_ben) begin
            // boot mode hands the cpu to the built-in loader
            start_d = BOOTSEL_BOOT;
        end
    end

    // ****************************************************************
    // flip-flops
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        pin_meta_q <= {test_pin, boot_select_pin, boot_enable_pin};
        pin_sync_q <= pin_meta_q;
    end

    // pins are caught once, in the first cycle after release; the
    // synchroniser delay sits inside the settle time the pins allow
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            started_q <= 1'b0;
            user_q <= 1'b0;
            boot_q <= 1'b0;
        end else if (!started_q) begin
            started_q <= 1'b1;
            user_q <= (start_d == BOOTSEL_USER);
            boot_q <= (start_d == BOOTSEL_BOOT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode_q <= `RST_MODE_CONTROL;
            blk_q <= `RST_BLOCK_SELECT;
            error_q <= 1'b0;
            pdwn_dis_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            blk_q <= blk_d;
            error_q <= error_d;
            pdwn_dis_q <= pdwn_dis_d;
            gate_q <= gate_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            modes_q <= '0;
            blk_en_q <= 5'h00;
            addr_ok_q <= 1'b0;
            pwdn_q <= 1'b0;
        end else begin
            modes_q <= modes_d;
            blk_en_q <= blk_en_d;
            addr_ok_q <= addr_ok_d;
            pwdn_q <= pwdn_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign array_modes = modes_q;
    assign block_erase_enable = blk_en_q;
    assign erase_addr_allowed = addr_ok_q;
    assign array_powerdown = pwdn_q;
    assign array_error = error_q;
    assign user_mode = user_q;
    assign boot_mode = boot_q;

    wire unused_ok = wr_stat_dropped | (|writedata[31:8]) | (|byteenable[3:1]) |
        (|address) | (|array_addr);

endmodule // flash_program_erase_control

/* File: test/flash_ctrl_properties.sv */
`include "flash_ctrl_consts.svh"

module flash_ctrl_properties (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic array_fault,
    input wire logic subactive_req,
    input wire flash_ctrl_pkg::array_modes_t array_modes,
    input wire logic [`BLOCK_COUNT-1:0] block_erase_enable,
    input wire logic array_powerdown,
    input wire logic array_error,
    input wire logic user_mode,
    input wire logic boot_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import flash_ctrl_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ****************************************************************
    // register bus
    // ****************************************************************
    AST_BUS_ANSWER: assert property (
        (read || write) && waitrequest |-> ##[0:3] !waitrequest)
        else $error("bus request left unanswered");
    AST_BUS_PULSE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_READ_UPPER_ZERO: assert property (
        read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("read data upper lanes not zero");

    // ****************************************************************
    // array modes and blocks
    // ****************************************************************
    // entry checked on the rising edge only: setup may legally drop later
    AST_ERASE_ENTRY: assert property (
        $rose(array_modes.erase_mode) |-> $past(array_modes.erase_setup))
        else $error("erase mode entered without erase setup");
    AST_PROGRAM_ENTRY: assert property (
        $rose(array_modes.program_mode) |-> $past(array_modes.program_setup))
        else $error("program mode entered without program setup");
    AST_ONE_BLOCK: assert property ($onehot0(block_erase_enable))
        else $error("more than one block enabled for erase");
    AST_BLOCK_NEEDS_ERASE: assert property (
        |block_erase_enable |-> array_modes.erase_mode || $past(array_modes.erase_mode))
        else $error("block enabled outside erase mode");

    // ****************************************************************
    // error protection, power, start mode
    // ****************************************************************
    AST_FAULT_SETS_ERROR: assert property (
        array_fault && (array_modes.erase_mode || array_modes.program_mode) |=> array_error)
        else $error("fault during operation did not raise error");
    AST_ERROR_STICKY: assert property (array_error |=> array_error)
        else $error("error flag dropped without reset");
    AST_ERROR_STOPS: assert property (
        array_error |-> !array_modes.erase_mode && !array_modes.program_mode)
        else $error("erase or program active under error protection");
    AST_POWERDOWN_IDLE: assert property (!subactive_req |=> !array_powerdown)
        else $error("power-down outside subactive");
    AST_START_HELD: assert property (
        $past(rstn, 2) |-> $stable(user_mode) && $stable(boot_mode) &&
        !(user_mode && boot_mode))
        else $error("start mode changed or doubled after reset");
endmodule // flash_ctrl_properties

bind flash_program_erase_control flash_ctrl_properties chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .array_fault(array_fault), .subactive_req(subactive_req),
    .array_modes(array_modes), .block_erase_enable(block_erase_enable),
    .array_powerdown(array_powerdown), .array_error(array_error),
    .user_mode(user_mode), .boot_mode(boot_mode)
);

/* File: test/flash_program_erase_control_tb_top.sv */
module flash_program_erase_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_ctrl_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h1;
    logic [14:0] array_addr = 15'h0;
    logic array_fault = 1'b0;
    logic subactive_req = 1'b0;
    logic test_pin = 1'b0;
    logic boot_select_pin = 1'b1;
    logic boot_enable_pin = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, erase_addr_allowed, array_powerdown, array_error, user_mode, boot_mode;
    array_modes_t array_modes;
    logic [4:0] block_erase_enable;
    logic [7:0] q;
    int fail_count = 0;
    int checks_done = 0;

    always #2.5 sys_clk = ~sys_clk;

    flash_program_erase_control dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .array_addr(array_addr), .array_fault(array_fault),
        .subactive_req(subactive_req), .array_modes(array_modes),
        .block_erase_enable(block_erase_enable), .erase_addr_allowed(erase_addr_allowed),
        .array_powerdown(array_powerdown), .array_error(array_error), .test_pin(test_pin),
        .boot_select_pin(boot_select_pin), .boot_enable_pin(boot_enable_pin),
        .user_mode(user_mode), .boot_mode(boot_mode)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one byte per access; the request stays up until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        read <= ~wr;
        write <= wr;
        // no local limit: only the watchdog ends a wait that never sees the answer
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check({24'h0, q}, {24'h0, exp});
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // erase_addr_allowed follows array_addr one cycle late
    task automatic probe(input logic [14:0] a, input logic exp);
        @(posedge sys_clk);
        array_addr <= a;
        repeat (2) @(negedge sys_clk);
        check({31'h0, erase_addr_allowed}, {31'h0, exp});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic gate_and_power();
        for (int i = 0; i < 6; i++) rdchk(i[5:0], 8'h00);
        bus(1'b1, 6'h02, 8'h80);
        bus(1'b1, 6'h04, 8'hff);
        rdchk(6'h04, 8'h80);
        rdchk(6'h02, 8'h00);
        bus(1'b1, 6'h02, 8'hff);
        rdchk(6'h02, 8'h80);
        @(posedge sys_clk);
        byteenable <= 4'h0;
        bus(1'b1, 6'h02, 8'h00);
        @(posedge sys_clk);
        byteenable <= 4'h1;
        rdchk(6'h02, 8'h80);
        bus(1'b1, 6'h01, 8'hff);
        rdchk(6'h01, 8'h00);
        @(posedge sys_clk);
        subactive_req <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check({31'h0, array_powerdown}, 32'h0);
        bus(1'b1, 6'h02, 8'h00);
        repeat (2) @(negedge sys_clk);
        check({31'h0, array_powerdown}, 32'h1);
        @(posedge sys_clk);
        subactive_req <= 1'b0;
    endtask

    task automatic write_enable_gate();
        bus(1'b1, 6'h00, 8'h20);
        rdchk(6'h00, 8'h00);
        bus(1'b1, 6'h03, 8'h01);
        rdchk(6'h03, 8'h00);
        bus(1'b1, 6'h00, 8'h40);
        bus(1'b1, 6'h03, 8'h01);
        rdchk(6'h03, 8'h01);
        bus(1'b1, 6'h00, 8'h60);
        bus(1'b1, 6'h00, 8'h00);
        rdchk(6'h00, 8'h00);
        rdchk(6'h03, 8'h00);
    endtask

    task automatic setup_verify();
        bus(1'b1, 6'h00, 8'h40);
        for (int b = 2; b < 6; b++) begin
            bus(1'b1, 6'h00, 8'h40 | (8'h01 << b));
            rdchk(6'h00, 8'h40 | (8'h01 << b));
            check({26'h0, array_modes}, 32'h1 << (5 - b));
        end
        bus(1'b1, 6'h00, 8'h40);
        check({26'h0, array_modes}, 32'h0);
    endtask

    task automatic erase_blocks();
        logic [14:0] base[5] = '{15'h0000, 15'h0400, 15'h0800, 15'h0c00, 15'h1000};
        logic [14:0] top[5] = '{15'h03ff, 15'h07ff, 15'h0bff, 15'h0fff, 15'h7fff};
        bus(1'b1, 6'h00, 8'h42);
        check({31'h0, array_modes.erase_mode}, 32'h0);
        bus(1'b1, 6'h00, 8'h60);
        bus(1'b1, 6'h03, 8'h03);
        rdchk(6'h03, 8'h00);
        bus(1'b1, 6'h00, 8'h62);
        check({31'h0, array_modes.erase_mode}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 6'h03, 8'h01 << i);
            check({27'h0, block_erase_enable}, 32'h1 << i);
            probe(base[i], 1'b1);
            probe(top[i], 1'b1);
            probe(i < 4 ? top[i] + 15'h1 : base[i] - 15'h1, 1'b0);
        end
        bus(1'b1, 6'h00, 8'h40);
        check({27'h0, block_erase_enable}, 32'h0);
    endtask

    task automatic program_error();
        bus(1'b1, 6'h00, 8'h41);
        check({31'h0, array_modes.program_mode}, 32'h0);
        bus(1'b1, 6'h00, 8'h50);
        bus(1'b1, 6'h00, 8'h51);
        check({31'h0, array_modes.program_mode}, 32'h1);
        @(posedge sys_clk);
        array_fault <= 1'b1;
        @(posedge sys_clk);
        array_fault <= 1'b0;
        @(negedge sys_clk);
        check({30'h0, array_error, array_modes.program_mode}, 32'h2);
        rdchk(6'h01, 8'h80);
        bus(1'b1, 6'h00, 8'h51);
        check({31'h0, array_modes.program_mode}, 32'h0);
    endtask

    // pins change one cycle before the edge that starts reset, so they settle well before release
    task automatic startup();
        logic [4:0] t[4] = '{5'b01010, 5'b00101, 5'b11100, 5'b00000};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {test_pin, boot_select_pin, boot_enable_pin} <= t[i][4:2];
            do_reset();
            check({30'h0, user_mode, boot_mode}, {30'h0, t[i][1:0]});
        end
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        do_reset();
        gate_and_power();
        write_enable_gate();
        setup_verify();
        erase_blocks();
        program_error();
        startup();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        conclude();
    end
endmodule // flash_program_erase_control_tb_top
